// >>> src/dopwm_top.sv
// dual output pulse-width modulator with byte register interface
//
// Functional notes
// - mode bits 6..4 select off, single16, twin8, twin16, dual8 operation.
// - mode 100 gives two independent 16-bit non-return-to-zero density outputs.
// - mode 110 gives two independent 16-bit return-to-zero density outputs.
// - mode 111 holds counter in reset, outputs unused.
// - bits 1..0 pick crystal/15, crystal, external pin, or pll clock.
// - control bit 7 is not implemented; writes ignored, reads zero.
// - any control write resets the modulation counter.
// - low byte writes land in a hidden holding register.
// - high byte write loads high and held low byte together.
// - pwm modes take new values at the next cycle boundary; density modes at the next tick.
// - output duty comes from the two register pairs.
// - two modes act as sigma-delta bitstreams up to 16 bits.
// - single16: period from second pair, duty from first pair.
// - twin16: high below compare, low from equality until rollover.
// - density modes step every modulator tick, high count per 65536.
// - when disabled both pins are released to ordinary port use.
`timescale 1ns/1ps
module dopwm_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic crystal_clock,
  input wire logic pll_clock,
  input wire logic external_clock_pin,
  output logic first_output_pin,
  output logic second_output_pin,
  output logic first_output_active,
  output logic second_output_active
);
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] modulator_control;
  logic [15:0] duty_reg;
  logic [15:0] period_reg;
  logic [7:0] hidden_low;
  logic [15:0] duty_live;
  logic [15:0] period_live;
  logic ctrl_wr;
  dopwm_pkg::dopwm_mode_t mode;
  assign ctrl_wr = clk_en & sfr_wr & (sfr_addr == dopwm_pkg::addr_modulator_control);
  assign mode = dopwm_pkg::dopwm_mode_t'(modulator_control[dopwm_pkg::mode_msb:dopwm_pkg::mode_lsb]);

  // control register, bit 7 never stored
  always_ff @(posedge clock) begin
    if (srst) begin
      modulator_control <= dopwm_pkg::reset_byte;
    end else if (ctrl_wr) begin
      modulator_control <= sfr_wdata & dopwm_pkg::control_write_mask;
    end
  end

  // hidden holding byte shared by both low-byte addresses
  always_ff @(posedge clock) begin
    if (srst) begin
      hidden_low <= dopwm_pkg::reset_byte;
    end else if (clk_en && sfr_wr && (sfr_addr == dopwm_pkg::addr_duty_low_byte ||
                                      sfr_addr == dopwm_pkg::addr_period_low_byte)) begin
      hidden_low <= sfr_wdata;
    end
  end

  // visible pairs: high byte write commits the held low byte too
  always_ff @(posedge clock) begin
    if (srst) begin
      duty_reg <= 16'h0000;
      period_reg <= 16'h0000;
    end else if (clk_en && sfr_wr) begin
      if (sfr_addr == dopwm_pkg::addr_duty_high_byte) begin
        duty_reg <= {sfr_wdata, hidden_low};
      end
      if (sfr_addr == dopwm_pkg::addr_period_high_byte) begin
        period_reg <= {sfr_wdata, hidden_low};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // clock source and prescaler
  logic xtal_rise;
  logic ext_rise;
  logic [3:0] xtal15_cnt;
  logic src_tick;
  logic [5:0] pre_cnt;
  logic [5:0] pre_last;
  logic tick;

  dopwm_edge u_xtal_edge (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .level(crystal_clock),
    .rise(xtal_rise)
  );
  dopwm_edge u_ext_edge (
    .clock(clock),
    .srst(srst),
    .clk_en(clk_en),
    .level(external_clock_pin),
    .rise(ext_rise)
  );

  // crystal divided by fifteen
  always_ff @(posedge clock) begin
    if (srst) begin
      xtal15_cnt <= 4'h0;
    end else if (clk_en && xtal_rise) begin
      xtal15_cnt <= (xtal15_cnt == dopwm_pkg::xtal_div15_last) ? 4'h0 : xtal15_cnt + 4'h1;
    end
  end

  // source select; pll clock arrives as a level sampled here, so one tick per clock at most
  always_comb begin
    unique case (modulator_control[dopwm_pkg::source_msb:dopwm_pkg::source_lsb])
      2'b00: src_tick = xtal_rise && (xtal15_cnt == dopwm_pkg::xtal_div15_last);
      2'b01: src_tick = xtal_rise;
      2'b10: src_tick = ext_rise;
      2'b11: src_tick = clk_en & pll_clock;
    endcase
  end

  always_comb begin
    unique case (modulator_control[dopwm_pkg::prescale_msb:dopwm_pkg::prescale_lsb])
      2'b00: pre_last = dopwm_pkg::div1_last;
      2'b01: pre_last = dopwm_pkg::div4_last;
      2'b10: pre_last = dopwm_pkg::div16_last;
      2'b11: pre_last = dopwm_pkg::div64_last;
    endcase
  end

  // prescaler restarts with the counter on a control write
  always_ff @(posedge clock) begin
    if (srst || ctrl_wr) begin
      pre_cnt <= 6'h00;
    end else if (src_tick) begin
      pre_cnt <= (pre_cnt == pre_last) ? 6'h00 : pre_cnt + 6'h01;
    end
  end
  assign tick = src_tick && (pre_cnt == pre_last);

  ////////////////////////////////////////////////////////////////////////
  // modulation counter
  logic [15:0] count;
  logic [15:0] next_count;
  logic cycle_end;
  logic counter_run;
  assign counter_run = (mode != dopwm_pkg::dopwm_off_e) && (mode != dopwm_pkg::dopwm_hold_e);

  // wrap point: single16 uses the period pair, twin8 the period low byte, dual8 wraps at 255
  always_comb begin
    unique case (mode)
      dopwm_pkg::dopwm_single16_e: cycle_end = (count == period_live - 16'h0001);
      dopwm_pkg::dopwm_twin8_e: cycle_end = (count[7:0] == period_live[7:0]);
      dopwm_pkg::dopwm_dual8_e: cycle_end = (count[7:0] == 8'hff);
      default: cycle_end = (count == 16'hffff);
    endcase
    next_count = cycle_end ? 16'h0000 : count + 16'h0001;
  end

  always_ff @(posedge clock) begin
    if (srst || ctrl_wr || !counter_run) begin
      count <= 16'h0000;
    end else if (tick) begin
      count <= next_count;
    end
  end

  // live copies load only at a cycle boundary, on a control write, or while the counter is stopped
  always_ff @(posedge clock) begin
    if (srst) begin
      duty_live <= 16'h0000;
      period_live <= 16'h0000;
    end else if (!counter_run || ctrl_wr || (tick && cycle_end)) begin
      duty_live <= duty_reg;
      period_live <= period_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // density generators
  logic sd0;
  logic sd1;
  logic sd_run;
  assign sd_run = (mode == dopwm_pkg::dopwm_nrz_e) || (mode == dopwm_pkg::dopwm_rz_e);

  // unlike the pwm modes, density levels follow the registers each tick
  dopwm_sigma u_sd0 (
    .clock(clock),
    .srst(srst),
    .step(tick & sd_run),
    .clear(ctrl_wr | ~sd_run),
    .level(duty_reg),
    .bit_out(sd0)
  );
  dopwm_sigma u_sd1 (
    .clock(clock),
    .srst(srst),
    .step(tick & sd_run),
    .clear(ctrl_wr | ~sd_run),
    .level(period_reg),
    .bit_out(sd1)
  );

  // return-to-zero: a high bit lasts the first half of its tick period, or the whole tick with divide-by-1
  logic rz_half;
  always_ff @(posedge clock) begin
    if (srst || tick) begin
      rz_half <= 1'b1;
    end else if (src_tick && pre_cnt >= (pre_last >> 1)) begin
      rz_half <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output waveforms
  logic next_out0;
  logic next_out1;
  always_comb begin
    next_out0 = 1'b0;
    next_out1 = 1'b0;
    unique case (mode)
      dopwm_pkg::dopwm_single16_e: next_out0 = count < duty_live;
      dopwm_pkg::dopwm_twin8_e: begin
        next_out0 = count[7:0] < duty_live[7:0];
        next_out1 = (count[7:0] >= period_live[15:8]) && (count[7:0] < duty_live[15:8]);
      end
      dopwm_pkg::dopwm_twin16_e: begin
        next_out0 = count < duty_live;
        next_out1 = count < period_live;
      end
      dopwm_pkg::dopwm_nrz_e: begin
        next_out0 = sd0;
        next_out1 = sd1;
      end
      dopwm_pkg::dopwm_dual8_e: begin
        next_out0 = count[7:0] < duty_live[7:0];
        next_out1 = count[7:0] < duty_live[15:8];
      end
      dopwm_pkg::dopwm_rz_e: begin
        next_out0 = sd0 & rz_half;
        next_out1 = sd1 & rz_half;
      end
      dopwm_pkg::dopwm_off_e, dopwm_pkg::dopwm_hold_e: begin
        next_out0 = 1'b0;
        next_out1 = 1'b0;
      end
    endcase
  end

  // registered pins; enables tell the port mux to hand pins back
  always_ff @(posedge clock) begin
    if (srst) begin
      first_output_pin <= 1'b0;
      second_output_pin <= 1'b0;
      first_output_active <= 1'b0;
      second_output_active <= 1'b0;
    end else if (clk_en) begin
      first_output_pin <= next_out0;
      second_output_pin <= next_out1;
      first_output_active <= counter_run;
      second_output_active <= counter_run && (mode != dopwm_pkg::dopwm_single16_e);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path, low addresses read the committed low bytes
  always_comb begin
    sfr_hit = 1'b1;
    unique case (sfr_addr)
      dopwm_pkg::addr_modulator_control: sfr_rdata = modulator_control;
      dopwm_pkg::addr_duty_low_byte: sfr_rdata = duty_reg[7:0];
      dopwm_pkg::addr_duty_high_byte: sfr_rdata = duty_reg[15:8];
      dopwm_pkg::addr_period_low_byte: sfr_rdata = period_reg[7:0];
      dopwm_pkg::addr_period_high_byte: sfr_rdata = period_reg[15:8];
      default: begin
        sfr_rdata = dopwm_pkg::reset_byte;
        sfr_hit = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_duty_low_wr;
    clk_en && sfr_wr && (sfr_addr == dopwm_pkg::addr_duty_low_byte);
  endsequence
  sequence s_bus_quiet;
    !(clk_en && sfr_wr);
  endsequence
  sequence s_duty_high_wr;
    clk_en && sfr_wr && (sfr_addr == dopwm_pkg::addr_duty_high_byte);
  endsequence
  a_bit7_zero: assert property (@(posedge clock) disable iff (srst)
    ctrl_wr |=> !modulator_control[7]) else $error("control bit 7 stored");
  a_ctrl_clears_count: assert property (@(posedge clock) disable iff (srst)
    ctrl_wr |=> count == 16'h0000) else $error("counter not reset by control write");
  // enable in the antecedent: a frozen clock leaves the pin enables where they were
  a_hold_mode_idle: assert property (@(posedge clock) disable iff (srst)
    clk_en && mode == dopwm_pkg::dopwm_hold_e |=> count == 16'h0000 && !first_output_active)
    else $error("hold mode not idle");
  a_high_commit: assert property (@(posedge clock) disable iff (srst)
    clk_en && sfr_wr && sfr_addr == dopwm_pkg::addr_duty_high_byte
    |=> duty_reg == {$past(sfr_wdata), $past(hidden_low)}) else $error("pair not committed");
  a_low_hidden: assert property (@(posedge clock) disable iff (srst)
    clk_en && sfr_wr && sfr_addr == dopwm_pkg::addr_duty_low_byte |=> $stable(duty_reg))
    else $error("low byte applied directly");
  a_live_stable: assert property (@(posedge clock) disable iff (srst)
    counter_run && !ctrl_wr && !(tick && cycle_end) |=> $stable(duty_live))
    else $error("compare changed mid cycle");
  a_count_step: assert property (@(posedge clock) disable iff (srst)
    tick && counter_run && !ctrl_wr && !cycle_end |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance");
  a_off_release: assert property (@(posedge clock) disable iff (srst)
    clk_en && mode == dopwm_pkg::dopwm_off_e |=> !first_output_active && !second_output_active)
    else $error("pins not released");
  a_twin16_out: assert property (@(posedge clock) disable iff (srst)
    clk_en && mode == dopwm_pkg::dopwm_twin16_e |=> first_output_pin == ($past(count) < $past(duty_live)))
    else $error("twin16 compare wrong");
  a_pair_order: assert property (@(posedge clock) disable iff (srst)
    s_duty_low_wr ##1 s_bus_quiet [*2] ##1 s_duty_high_wr |=> duty_reg[7:0] == $past(sfr_wdata, 4))
    else $error("held low byte lost");
endmodule : dopwm_top

// >>> src/dopwm_pkg.sv
// package for the dual output modulator: register map, fields, modes
package dopwm_pkg;
  // register addresses on the special-function bus
  localparam logic [7:0] addr_modulator_control = 8'hae;
  localparam logic [7:0] addr_duty_low_byte = 8'hb1;
  localparam logic [7:0] addr_duty_high_byte = 8'hb2;
  localparam logic [7:0] addr_period_low_byte = 8'hb3;
  localparam logic [7:0] addr_period_high_byte = 8'hb4;
  localparam logic [7:0] reset_byte = 8'h00;
  localparam logic [7:0] control_write_mask = 8'h7f;
  // control field positions
  localparam int mode_msb = 6;
  localparam int mode_lsb = 4;
  localparam int prescale_msb = 3;
  localparam int prescale_lsb = 2;
  localparam int source_msb = 1;
  localparam int source_lsb = 0;
  // prescale terminal counts (divide minus one)
  localparam logic [5:0] div1_last = 6'h00;
  localparam logic [5:0] div4_last = 6'h03;
  localparam logic [5:0] div16_last = 6'h0f;
  localparam logic [5:0] div64_last = 6'h3f;
  localparam logic [3:0] xtal_div15_last = 4'he;
  typedef enum logic [2:0] {
    dopwm_off_e, dopwm_single16_e, dopwm_twin8_e, dopwm_twin16_e,
    dopwm_nrz_e, dopwm_dual8_e, dopwm_rz_e, dopwm_hold_e
  } dopwm_mode_t;
endpackage : dopwm_pkg

// >>> src/dopwm_edge.sv
// rising edge detector for the slow clock sources
`timescale 1ns/1ps
module dopwm_edge (
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic level,
  output logic rise
);
  logic prev;
  // previous sample, inputs already synchronous
  always_ff @(posedge clock) begin
    if (srst) begin
      prev <= 1'b0;
    end else if (clk_en) begin
      prev <= level;
    end
  end
  assign rise = clk_en & level & ~prev;
endmodule : dopwm_edge

// >>> src/dopwm_sigma.sv
// first order pulse-density accumulator for one output
`timescale 1ns/1ps
module dopwm_sigma (
  input wire logic clock,
  input wire logic srst,
  input wire logic step,
  input wire logic clear,
  input wire logic [15:0] level,
  output logic bit_out
);
  logic [15:0] acc;
  logic [16:0] sum;
  assign sum = {1'b0, acc} + {1'b0, level};
  // carry out is the density bit: high exactly level times per 65536 steps
  always_ff @(posedge clock) begin
    if (srst || clear) begin
      acc <= 16'h0000;
      bit_out <= 1'b0;
    end else if (step) begin
      acc <= sum[15:0];
      bit_out <= sum[16];
    end
  end
endmodule : dopwm_sigma

// >>> test/tb_dopwm_top.sv
// self-checking bench for the dual output modulator, with a byte-map model
`timescale 1ns/1ps
module tb_dopwm_top;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic sfr_hit;
  logic crystal_clock = 1'b0;
  logic pll_clock = 1'b1;
  logic external_clock_pin = 1'b0;
  logic first_output_pin, second_output_pin, first_output_active, second_output_active;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int h0, h1, a0, a1;
  int mreg[int];
  int hidden = 0;
  logic [7:0] rnd = 8'h3c;
  logic [7:0] lo;
  logic [7:0] addrs[5] = '{8'hae, 8'hb1, 8'hb2, 8'hb3, 8'hb4};
  int src_per[4] = '{30, 2, 4, 1};
  int div_of[4] = '{1, 4, 16, 64};

  ////////////////////////////////////////////////////////////////////////////
  always #25 clock = ~clock;

  dopwm_top u_dut (.clock(clock), .srst(srst), .clk_en(clk_en), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .crystal_clock(crystal_clock), .pll_clock(pll_clock), .external_clock_pin(external_clock_pin),
    .first_output_pin(first_output_pin), .second_output_pin(second_output_pin),
    .first_output_active(first_output_active), .second_output_active(second_output_active));

  // slow sources: crystal rises every 2 cycles, external pin every 4
  always @(negedge clock) begin
    crystal_clock <= ~crystal_clock;
    if (cycles[0]) external_clock_pin <= ~external_clock_pin;
  end

  // hang guard, well above the roughly 8400 cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  // counts outside zero tolerance are pin-cycle counts, never unknown
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    tests_run++;
    if (got !== exp && !(^got !== 1'bx && got + tol >= exp && got <= exp + tol)) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // write held across one rising edge; model keeps the shared hidden low byte
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clock);
    sfr_wr = 1'b0;
    if (a == 8'hae) mreg[a] = d & 8'h7f;
    else if (a == 8'hb1 || a == 8'hb3) hidden = d;
    else if (a == 8'hb2 || a == 8'hb4) begin
      mreg[a] = d;
      mreg[a - 8'h01] = hidden;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic hit);
    @(negedge clock);
    sfr_addr = a;
    sfr_rd = 1'b1;
    #1;
    chk({24'h0, sfr_rdata}, mreg.exists(a) ? mreg[a] : 0, 0);
    chk({31'h0, sfr_hit}, {31'h0, hit}, 0);
    sfr_rd = 1'b0;
  endtask : rd

  task automatic setpair(input logic [7:0] lo_a, input logic [15:0] v);
    wr(lo_a, v[7:0]);
    rd(lo_a, 1'b1);
    wr(lo_a + 8'h01, v[15:8]);
    rd(lo_a, 1'b1);
    rd(lo_a + 8'h01, 1'b1);
  endtask : setpair

  task automatic measure(input int n);
    h0 = 0;
    h1 = 0;
    a0 = 0;
    a1 = 0;
    repeat (n) begin
      @(negedge clock);
      if (first_output_pin === 1'b1) h0++;
      if (second_output_pin === 1'b1) h1++;
      if (first_output_active === 1'b1) a0++;
      if (second_output_active === 1'b1) a1++;
    end
  endtask : measure

  task automatic run(input logic [7:0] ctrl, input int n);
    wr(8'hae, ctrl);
    measure(n);
  endtask : run

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 5; i++) mreg[addrs[i]] = 0;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    // reset values, an unmapped place, the unused control bit
    for (int i = 0; i < 5; i++) rd(addrs[i], 1'b1);
    wr(8'hb5, 8'h5a);
    rd(8'hb5, 1'b0);
    wr(8'hae, 8'hff);
    rd(8'hae, 1'b1);
    // random pairs, low byte first
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr_next(rnd);
      lo = rnd;
      rnd = lfsr_next(rnd);
      setpair(i[0] ? 8'hb3 : 8'hb1, {rnd, lo});
    end
    $display("test registers done");
    // twin 16-bit across every source, then every divider
    wr(8'hae, 8'h00);
    setpair(8'hb1, 16'h0010);
    setpair(8'hb3, 16'h0020);
    for (int s = 0; s < 4; s++) begin
      run(8'h30 | s[7:0], 40 * src_per[s]);
      chk(h0, 16 * src_per[s], src_per[s] + 1);
      chk(h1, 32 * src_per[s], src_per[s] + 1);
    end
    chk(a0, 40, 2);
    chk(a1, 40, 2);
    for (int p = 0; p < 4; p++) begin
      run(8'h33 | (p[7:0] << 2), 40 * div_of[p]);
      chk(h0, 16 * div_of[p], div_of[p] + 1);
    end
    // enable low mid-pulse: pin holds high, the rest of the pulse follows later
    run(8'h33, 8);
    clk_en = 1'b0;
    measure(20);
    chk(h0, 20, 0);
    clk_en = 1'b1;
    measure(40);
    chk(h0, 8, 0);
    $display("test sources done");
    // new value mid-cycle must wait for the rollover
    run(8'h33, 60);
    setpair(8'hb1, 16'h0080);
    measure(200);
    chk(h0, 0, 0);
    $display("test deferred update done");
    // single 16-bit, twin 8-bit, dual 8-bit
    setpair(8'hb1, 16'h0008);
    setpair(8'hb3, 16'h0020);
    run(8'h13, 320);
    chk(h0, 80, 3);
    chk(h1, 0, 0);
    chk(a1, 0, 0);
    setpair(8'hb1, 16'h0c08);
    setpair(8'hb3, 16'h041f);
    run(8'h23, 320);
    chk(h0, 80, 3);
    chk(h1, 80, 3);
    setpair(8'hb1, 16'h8040);
    run(8'h53, 1024);
    chk(h0, 256, 4);
    chk(h1, 512, 4);
    $display("test pulse modes done");
    // density modes: quarter and three quarters of full scale
    setpair(8'hb1, 16'h4000);
    setpair(8'hb3, 16'hc000);
    run(8'h43, 256);
    chk(h0, 64, 2);
    chk(h1, 192, 2);
    run(8'h67, 1024);
    chk(h0, 128, 4);
    chk(h1, 384, 4);
    $display("test density modes done");
    // held and disabled: pins go back to the port
    run(8'h70, 40);
    chk(a0 + a1, 0, 0);
    run(8'h00, 40);
    chk(a0 + a1, 0, 0);
    $display("test release done");
    give_verdict();
  end
endmodule : tb_dopwm_top
